// ### design/twac_top.sv
// tooth wheel angle tick counter with register port
// ****************************************
// ****************************************
//
// Decided for this implementation: the register offsets and strobed register access.
module twac_top (
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic tooth_in,
	output logic [31:0] rd_data_out,
	output logic [23:0] angle_out,
	output logic compare_hit_out,
	output logic [3:0] mode_out
);

	// ****************************************
	// tooth input synchroniser
	// ****************************************
	logic [2:0] tooth_sync;
	logic tooth_level;
	logic tooth_pulse;
	logic [2:0] next_tooth_sync;
	logic next_tooth_level;
	logic next_tooth_pulse;
	logic tooth_agree;

	always_comb begin
		next_tooth_sync = {tooth_sync[1:0], tooth_in};
		tooth_agree = (tooth_sync[1] == tooth_sync[2]);
		next_tooth_level = tooth_agree ? tooth_sync[2] : tooth_level;
		// rising edge once both late stages agree
		next_tooth_pulse = tooth_agree && tooth_sync[2] && !tooth_level;
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			tooth_sync <= 3'h0;
			tooth_level <= 1'b0;
			tooth_pulse <= 1'b0;
		end else begin
			tooth_sync <= next_tooth_sync;
			tooth_level <= next_tooth_level;
			tooth_pulse <= next_tooth_pulse;
		end
	end

	// ****************************************
	// time base counter
	// ****************************************
	logic [7:0] tbdiv;
	logic [7:0] tb_div_cnt;
	logic [23:0] time_base_counter;
	logic tb_tick;
	logic [7:0] next_tb_div_cnt;
	logic [23:0] next_time_base_counter;
	logic next_tb_tick;

	always_comb begin
		next_tb_div_cnt = tb_div_cnt + 8'h01;
		next_time_base_counter = time_base_counter;
		next_tb_tick = 1'b0;
		if (tb_div_cnt + 8'h01 >= tbdiv) begin
			next_tb_div_cnt = 8'h00;
			next_tb_tick = 1'b1;
			next_time_base_counter = time_base_counter + 24'h000001;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			tb_div_cnt <= 8'h00;
			time_base_counter <= 24'h000000;
			tb_tick <= 1'b0;
		end else begin
			tb_div_cnt <= next_tb_div_cnt;
			time_base_counter <= next_time_base_counter;
			tb_tick <= next_tb_tick;
		end
	end

	// ****************************************
	// angle core and registers
	// ****************************************
	twac_pkg::twac_state_t state;
	twac_pkg::twac_state_t next_state;
	logic [23:0] angle_counter;
	logic [9:0] tick_cnt;
	logic [15:0] rate_cnt;
	logic [15:0] rate_target;
	logic [8:0] frac_acc;
	logic [2:0] hr_cnt;
	logic last_latched;
	logic [9:0] ticks;
	logic [3:0] missing_tooth_count;
	logic last;
	logic hold;
	logic [23:0] tick_rate_value;
	logic [23:0] cmp;
	logic [9:0] sh_ticks;
	logic [3:0] sh_miss;
	logic sh_last;
	logic buf_pending;
	logic cmp_hit;
	logic [31:0] rd_data;
	logic [23:0] next_angle_counter;
	logic [9:0] next_tick_cnt;
	logic [15:0] next_rate_cnt;
	logic [15:0] next_rate_target;
	logic [8:0] next_frac_acc;
	logic [2:0] next_hr_cnt;
	logic next_last_latched;
	logic [9:0] next_ticks;
	logic [3:0] next_missing_tooth_count;
	logic next_last;
	logic next_hold;
	logic [23:0] next_tick_rate_value;
	logic [23:0] next_cmp;
	logic [7:0] next_tbdiv;
	logic [9:0] next_sh_ticks;
	logic [3:0] next_sh_miss;
	logic next_sh_last;
	logic next_buf_pending;
	logic next_cmp_hit;
	logic [31:0] next_rd_data;
	logic insert_ev;
	logic rate_expire;
	logic apply_buf;
	logic [9:0] frac_sum;
	logic [15:0] int_period;
	logic [23:0] cmp_diff;

	always_comb begin
		next_state = state;
		next_angle_counter = angle_counter;
		next_tick_cnt = tick_cnt;
		next_rate_cnt = rate_cnt;
		next_rate_target = rate_target;
		next_frac_acc = frac_acc;
		next_hr_cnt = hr_cnt;
		next_last_latched = last_latched;
		next_ticks = ticks;
		next_missing_tooth_count = missing_tooth_count;
		next_last = last;
		next_hold = hold;
		next_tick_rate_value = tick_rate_value;
		next_cmp = cmp;
		next_tbdiv = tbdiv;
		next_sh_ticks = sh_ticks;
		next_sh_miss = sh_miss;
		next_sh_last = sh_last;
		next_buf_pending = buf_pending;
		next_rd_data = 32'h00000000;
		apply_buf = 1'b0;
		insert_ev = wr_en_in && (addr_in == twac_pkg::OFS_TPR)
			&& wr_data_in[twac_pkg::INSERT_BIT];
		rate_expire = tb_tick && (rate_cnt + 16'h0001 == rate_target);
		frac_sum = {1'b0, frac_acc}
			+ {1'b0, tick_rate_value[twac_pkg::TRR_FRAC_W-1:0]};
		int_period = {1'b0, tick_rate_value[twac_pkg::TRR_W-1:
			twac_pkg::TRR_FRAC_W]};
		if (int_period == 16'h0000) begin
			int_period = twac_pkg::INT_ZERO_PERIOD;
		end

		unique case (state)
			twac_pkg::ST_NORMAL: begin
				if (hold) begin
					next_state = twac_pkg::ST_HOLD;
				end else if (tooth_pulse || insert_ev) begin
					if (tick_cnt >= ticks) begin
						// tooth in the closing period
						next_angle_counter = last ? 24'h000000
							: angle_counter + 24'h000001;
						next_last = 1'b0;
						next_tick_cnt = 10'h000;
						next_rate_cnt = 16'h0000;
					end else begin
						// early tooth or insert
						next_state = twac_pkg::ST_HIGH;
						next_last_latched = last;
						next_hr_cnt = 3'h0;
					end
				end else if (tb_tick) begin
					next_rate_cnt = rate_cnt + 16'h0001;
					if (rate_expire) begin
						// fraction accumulation
						next_rate_cnt = 16'h0000;
						next_frac_acc = frac_sum[8:0];
						next_rate_target = int_period
							+ {15'h0000, frac_sum[9]};
						if (tick_cnt < ticks) begin
							// live tick count
							next_angle_counter = angle_counter
								+ 24'h000001;
							next_tick_cnt = tick_cnt + 10'h001;
						end else if (missing_tooth_count != 4'h0) begin
							// inserted tooth
							next_missing_tooth_count =
								missing_tooth_count - 4'h1;
							next_angle_counter = angle_counter
								+ 24'h000001;
							next_tick_cnt = 10'h000;
						end else begin
							// one period after last tick
							next_state = twac_pkg::ST_HALT;
						end
					end
				end
			end
			twac_pkg::ST_HIGH: begin
				// insert is ignored here
				if (hold) begin
					next_state = twac_pkg::ST_HOLD;
					// leaving high rate releases held fields
					apply_buf = 1'b1;
				end else begin
					next_hr_cnt = hr_cnt + 3'h1;
					if (hr_cnt == twac_pkg::HR_LAST) begin
						if (tick_cnt < ticks) begin
							next_angle_counter = angle_counter
								+ 24'h000001;
							next_tick_cnt = tick_cnt + 10'h001;
						end else begin
							// deferred flagged reset
							next_angle_counter = last_latched
								? 24'h000000 : angle_counter + 24'h000001;
							if (last_latched) begin
								next_last = 1'b0;
							end
							next_tick_cnt = 10'h000;
							next_rate_cnt = 16'h0000;
							next_state = twac_pkg::ST_NORMAL;
							apply_buf = 1'b1;
						end
					end
				end
			end
			twac_pkg::ST_HALT: begin
				if (hold) begin
					next_state = twac_pkg::ST_HOLD;
				end else if (tooth_pulse || insert_ev) begin
					// tooth counted at once
					next_angle_counter = last ? 24'h000000
						: angle_counter + 24'h000001;
					next_last = 1'b0;
					next_tick_cnt = 10'h000;
					next_rate_cnt = 16'h0000;
					next_state = twac_pkg::ST_NORMAL;
				end
			end
			twac_pkg::ST_HOLD: begin
				if (tooth_pulse) begin
					// resume from frozen angle
					next_hold = 1'b0;
					next_tick_cnt = 10'h000;
					next_rate_cnt = 16'h0000;
					next_state = twac_pkg::ST_NORMAL;
				end else if (!hold) begin
					next_state = twac_pkg::ST_NORMAL;
				end
			end
			default: begin
				next_state = twac_pkg::ST_HALT;
			end
		endcase

		// register writes win over hardware updates
		if (wr_en_in) begin
			case (addr_in)
				twac_pkg::OFS_TPR: begin
					next_hold = wr_data_in[twac_pkg::HOLD_BIT];
					if (state == twac_pkg::ST_HIGH) begin
						// fields held back
						next_sh_ticks = wr_data_in[9:0];
						next_sh_miss = wr_data_in[13:10];
						next_sh_last = wr_data_in[twac_pkg::LAST_BIT];
						next_buf_pending = 1'b1;
					end else begin
						next_ticks = wr_data_in[9:0];
						next_missing_tooth_count = wr_data_in[13:10];
						next_last = wr_data_in[twac_pkg::LAST_BIT];
					end
				end
				twac_pkg::OFS_TRR: begin
					next_tick_rate_value = wr_data_in[23:0];
				end
				twac_pkg::OFS_TBDIV: begin
					next_tbdiv = wr_data_in[7:0];
				end
				twac_pkg::OFS_CMP: begin
					next_cmp = wr_data_in[23:0];
				end
				default: begin
				end
			endcase
		end
		if (apply_buf && next_buf_pending) begin
			// release on high rate exit
			next_ticks = next_sh_ticks;
			next_missing_tooth_count = next_sh_miss;
			next_last = next_sh_last;
			next_buf_pending = 1'b0;
		end

		// wrap-aware greater-or-equal compare
		cmp_diff = angle_counter - cmp;
		next_cmp_hit = (cmp_diff <= twac_pkg::HALF_RANGE);

		if (rd_en_in) begin
			case (addr_in)
				twac_pkg::OFS_TPR: begin
					next_rd_data = {13'h0000, hold, 1'b0, last, 2'h0,
						missing_tooth_count, ticks};
				end
				twac_pkg::OFS_TRR: begin
					next_rd_data = {8'h00, tick_rate_value};
				end
				twac_pkg::OFS_TBDIV: begin
					next_rd_data = {24'h000000, tbdiv};
				end
				twac_pkg::OFS_CMP: begin
					next_rd_data = {8'h00, cmp};
				end
				twac_pkg::OFS_ANGLE: begin
					next_rd_data = {8'h00, angle_counter};
				end
				twac_pkg::OFS_TBASE: begin
					next_rd_data = {8'h00, time_base_counter};
				end
				twac_pkg::OFS_STATUS: begin
					next_rd_data = {26'h0000000, cmp_hit, buf_pending,
						state};
				end
				default: begin
					next_rd_data = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			state <= twac_pkg::ST_HALT;
			angle_counter <= 24'h000000;
			tick_cnt <= 10'h000;
			rate_cnt <= 16'h0000;
			rate_target <= twac_pkg::RATE_TARGET_RST;
			frac_acc <= 9'h000;
			hr_cnt <= 3'h0;
			last_latched <= 1'b0;
			ticks <= twac_pkg::TICKS_RST;
			missing_tooth_count <= twac_pkg::MISS_RST;
			last <= 1'b0;
			hold <= 1'b0;
			tick_rate_value <= twac_pkg::TRR_RST;
			cmp <= twac_pkg::CMP_RST;
			tbdiv <= twac_pkg::TBDIV_RST;
			sh_ticks <= twac_pkg::TICKS_RST;
			sh_miss <= twac_pkg::MISS_RST;
			sh_last <= 1'b0;
			buf_pending <= 1'b0;
			cmp_hit <= 1'b0;
			rd_data <= 32'h00000000;
		end else begin
			state <= next_state;
			angle_counter <= next_angle_counter;
			tick_cnt <= next_tick_cnt;
			rate_cnt <= next_rate_cnt;
			rate_target <= next_rate_target;
			frac_acc <= next_frac_acc;
			hr_cnt <= next_hr_cnt;
			last_latched <= next_last_latched;
			ticks <= next_ticks;
			missing_tooth_count <= next_missing_tooth_count;
			last <= next_last;
			hold <= next_hold;
			tick_rate_value <= next_tick_rate_value;
			cmp <= next_cmp;
			tbdiv <= next_tbdiv;
			sh_ticks <= next_sh_ticks;
			sh_miss <= next_sh_miss;
			sh_last <= next_sh_last;
			buf_pending <= next_buf_pending;
			cmp_hit <= next_cmp_hit;
			rd_data <= next_rd_data;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign rd_data_out = rd_data;
	assign angle_out = angle_counter;
	assign compare_hit_out = cmp_hit;
	assign mode_out = state;

endmodule : twac_top

// ### shared/twac_pkg.sv
// constants and types shared by the tooth wheel angle tick counter
package twac_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] OFS_TPR = 8'h00;
	localparam logic [7:0] OFS_TRR = 8'h04;
	localparam logic [7:0] OFS_TBDIV = 8'h08;
	localparam logic [7:0] OFS_CMP = 8'h0c;
	localparam logic [7:0] OFS_ANGLE = 8'h10;
	localparam logic [7:0] OFS_TBASE = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;

	// ****************************************
	// field layout
	// ****************************************
	localparam int ANG_W = 24;
	localparam int TICKS_LSB = 0;
	localparam int TICKS_W = 10;
	localparam int MISS_LSB = 10;
	localparam int MISS_W = 4;
	localparam int LAST_BIT = 16;
	localparam int INSERT_BIT = 17;
	localparam int HOLD_BIT = 18;
	localparam int TRR_FRAC_W = 9;
	localparam int TRR_INT_W = 15;
	localparam int TRR_W = 24;
	localparam int TBDIV_W = 8;
	localparam int RATE_W = 16;
	localparam int ST_MODE_LSB = 0;
	localparam int ST_PEND_BIT = 4;
	localparam int ST_HIT_BIT = 5;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [9:0] TICKS_RST = 10'h063;
	localparam logic [3:0] MISS_RST = 4'h0;
	localparam logic [23:0] TRR_RST = 24'h000200;
	localparam logic [7:0] TBDIV_RST = 8'h02;
	localparam logic [23:0] CMP_RST = 24'h000000;
	localparam logic [15:0] RATE_TARGET_RST = 16'h0001;

	// ****************************************
	// timing
	// ****************************************
	localparam logic [2:0] HR_LAST = 3'h7;
	localparam logic [15:0] INT_ZERO_PERIOD = 16'h8000;
	localparam logic [23:0] HALF_RANGE = 24'h7fffff;

	typedef enum logic [3:0] {
		ST_NORMAL = 4'b0001,
		ST_HIGH = 4'b0010,
		ST_HALT = 4'b0100,
		ST_HOLD = 4'b1000
	} twac_state_t;

endpackage : twac_pkg

// ### test/tb_tooth_wheel_angle_tick_counter.sv
// testbench for the tooth wheel angle tick counter
bind twac_top twac_checker twac_checker_inst (.sys_clk_in, .srst_in,
	.addr_in, .wr_data_in, .wr_en_in, .rd_en_in, .tooth_in, .rd_data_out,
	.angle_out, .compare_hit_out, .mode_out);
module tb_tooth_wheel_angle_tick_counter;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// signals and instances
	// ****************************************
	logic sys_clk_in = 1'h0;
	logic srst_in = 1'h1;
	logic [7:0] addr_in = 8'h00;
	logic [31:0] wr_data_in = 32'h0;
	logic wr_en_in = 1'h0;
	logic rd_en_in = 1'h0;
	logic fire = 1'h0;
	logic tooth_in;
	logic [31:0] rd_data_out;
	logic [23:0] angle_out;
	logic compare_hit_out;
	logic [3:0] mode_out;
	logic [31:0] rv;
	logic [23:0] a0;
	int num_errors = 0;
	int checks = 0;
	twac_top twac_top_inst (.sys_clk_in, .srst_in, .addr_in, .wr_data_in,
		.wr_en_in, .rd_en_in, .tooth_in, .rd_data_out, .angle_out,
		.compare_hit_out, .mode_out);
	twac_tooth_model twac_tooth_model_inst (.sys_clk_in, .fire_in(fire),
		.len_in(4'h6), .tooth_out(tooth_in));
	initial forever #10 sys_clk_in = ~sys_clk_in;
	// ****************************************
	// helpers
	// ****************************************
	task automatic complete_run;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_en_in <= 1'h1;
		@(posedge sys_clk_in);
		wr_en_in <= 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk_in);
		addr_in <= a;
		rd_en_in <= 1'h1;
		@(posedge sys_clk_in);
		rd_en_in <= 1'h0;
		#1;
		rv = rd_data_out;
	endtask : rd
	task automatic wmode(input logic [3:0] m);
		int i;
		for (i = 0; i < 400 && mode_out !== m; i++) begin
			@(posedge sys_clk_in);
			#1;
		end
		chk("mode", 32'(m), 32'(mode_out));
	endtask : wmode
	task automatic tooth;
		@(posedge sys_clk_in);
		fire <= 1'h1;
		@(posedge sys_clk_in);
		fire <= 1'h0;
	endtask : tooth
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		rd(twac_pkg::OFS_TPR);
		chk("tpr", 32'h63, rv);
		rd(twac_pkg::OFS_TRR);
		chk("trr", 32'h200, rv);
		rd(twac_pkg::OFS_TBDIV);
		chk("tbdiv", 32'h2, rv);
		rd(8'h1c);
		chk("unmapped", 32'h0, rv);
		chk("mode", 32'(twac_pkg::ST_HALT), 32'(mode_out));
	endtask : t_reset
	task automatic t_ticks;
		a0 = angle_out;
		wr(twac_pkg::OFS_TPR, 32'h4);
		tooth;
		wmode(twac_pkg::ST_NORMAL);
		wmode(twac_pkg::ST_HALT);
		chk("angle", 32'(a0 + 24'h5), 32'(angle_out));
	endtask : t_ticks
	task automatic t_missing;
		a0 = angle_out;
		wr(twac_pkg::OFS_TPR, 32'h804);
		tooth;
		wmode(twac_pkg::ST_NORMAL);
		wmode(twac_pkg::ST_HALT);
		chk("angle", 32'(a0 + 24'hf), 32'(angle_out));
		rd(twac_pkg::OFS_TPR);
		chk("missing", 32'h0, 32'(rv[13:10]));
	endtask : t_missing
	task automatic t_flag;
		wr(twac_pkg::OFS_TPR, 32'h10004);
		tooth;
		wmode(twac_pkg::ST_NORMAL);
		chk("angle", 32'h0, 32'(angle_out));
		wmode(twac_pkg::ST_HALT);
		chk("angle", 32'h4, 32'(angle_out));
		rd(twac_pkg::OFS_TPR);
		chk("last", 32'h0, 32'(rv[16]));
	endtask : t_flag
	task automatic t_high;
		wr(twac_pkg::OFS_TRR, 32'h2800);
		wr(twac_pkg::OFS_TPR, 32'h4);
		tooth;
		wmode(twac_pkg::ST_NORMAL);
		repeat (60) @(posedge sys_clk_in);
		wr(twac_pkg::OFS_TPR, 32'h10004);
		tooth;
		wmode(twac_pkg::ST_HIGH);
		wr(twac_pkg::OFS_TPR, 32'h2);
		rd(twac_pkg::OFS_STATUS);
		chk("pending", 32'h1, 32'(rv[4]));
		wr(twac_pkg::OFS_TPR, 32'h20002);
		wmode(twac_pkg::ST_NORMAL);
		chk("angle", 32'h0, 32'(angle_out));
		rd(twac_pkg::OFS_TPR);
		chk("tpr", 32'h2, rv);
		repeat (10) @(posedge sys_clk_in);
		chk("angle", 32'h0, 32'(angle_out));
		chk("mode", 32'(twac_pkg::ST_NORMAL), 32'(mode_out));
	endtask : t_high
	task automatic t_insert;
		wmode(twac_pkg::ST_HALT);
		wr(twac_pkg::OFS_TPR, 32'h10002);
		wr(twac_pkg::OFS_TPR, 32'h20002);
		wmode(twac_pkg::ST_NORMAL);
		chk("angle", 32'h0, 32'(angle_out));
		wr(twac_pkg::OFS_TPR, 32'h20002);
		wmode(twac_pkg::ST_HIGH);
		wmode(twac_pkg::ST_NORMAL);
		chk("angle", 32'h3, 32'(angle_out));
	endtask : t_insert
	task automatic t_hold;
		wr(twac_pkg::OFS_TPR, 32'h40002);
		wmode(twac_pkg::ST_HOLD);
		a0 = angle_out;
		repeat (100) @(posedge sys_clk_in);
		chk("angle", 32'(a0), 32'(angle_out));
		tooth;
		wmode(twac_pkg::ST_NORMAL);
		chk("angle", 32'(a0), 32'(angle_out));
		rd(twac_pkg::OFS_TPR);
		chk("hold", 32'h0, 32'(rv[18]));
		wr(twac_pkg::OFS_TPR, 32'h40002);
		wmode(twac_pkg::ST_HOLD);
		a0 = angle_out;
		wr(twac_pkg::OFS_TPR, 32'h2);
		wmode(twac_pkg::ST_NORMAL);
		chk("angle", 32'(a0), 32'(angle_out));
	endtask : t_hold
	task automatic t_compare;
		wr(twac_pkg::OFS_CMP, 32'h100);
		repeat (3) @(posedge sys_clk_in);
		#1;
		chk("hit", 32'h0, 32'(compare_hit_out));
		rd(twac_pkg::OFS_STATUS);
		chk("hit bit", 32'h0, 32'(rv[5]));
		wr(twac_pkg::OFS_CMP, 32'h0);
		repeat (3) @(posedge sys_clk_in);
		#1;
		chk("hit", 32'h1, 32'(compare_hit_out));
		rd(twac_pkg::OFS_TBASE);
		a0 = rv[23:0];
		rd(twac_pkg::OFS_TBASE);
		chk("tbase", 32'(a0 + 24'h1), rv);
		wr(twac_pkg::OFS_TBDIV, 32'h1);
		rd(twac_pkg::OFS_TBASE);
		a0 = rv[23:0];
		rd(twac_pkg::OFS_TBASE);
		chk("tbase fast", 32'(a0 + 24'h2), rv);
	endtask : t_compare
	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial begin
		repeat (2) @(posedge sys_clk_in);
		srst_in <= 1'h0;
		t_reset;
		t_ticks;
		t_missing;
		t_flag;
		t_high;
		t_insert;
		t_hold;
		t_compare;
		complete_run;
	end
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		num_errors++;
		complete_run;
	end
endmodule : tb_tooth_wheel_angle_tick_counter

// ### test/twac_checker.sv
// assertion checker for the tooth wheel angle tick counter
module twac_checker (
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic tooth_in,
	input wire logic [31:0] rd_data_out,
	input wire logic [23:0] angle_out,
	input wire logic compare_hit_out,
	input wire logic [3:0] mode_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// compare shadow
	// ****************************************
	logic [23:0] cmp_s;
	logic [23:0] next_cmp_s;
	logic exp_hit;
	logic next_exp_hit;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (srst_in);
	always_comb begin
		next_cmp_s = cmp_s;
		if (wr_en_in && addr_in == twac_pkg::OFS_CMP)
			next_cmp_s = wr_data_in[23:0];
		next_exp_hit = (angle_out - cmp_s) <= twac_pkg::HALF_RANGE;
	end
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			cmp_s <= 24'h000000;
			exp_hit <= 1'h0;
		end else begin
			cmp_s <= next_cmp_s;
			exp_hit <= next_exp_hit;
		end
	end
	// ****************************************
	// properties
	// ****************************************
	AST_ANGLE_STEP:
	assert property ($changed(angle_out) |->
		angle_out == $past(angle_out) + 24'h1 || angle_out == 24'h0)
		else $error("angle moved by other than one step");
	AST_HOLD_FROZEN:
	assert property ($past(mode_out) == twac_pkg::ST_HOLD &&
		mode_out == twac_pkg::ST_HOLD |-> $stable(angle_out))
		else $error("angle moved during hold");
	AST_HIGH_SPACING:
	assert property (mode_out == twac_pkg::ST_HIGH && $changed(angle_out)
		|=> $stable(angle_out)[*7])
		else $error("high rate step faster than eight clocks");
	AST_HIGH_PROGRESS:
	assert property (mode_out == twac_pkg::ST_HIGH |-> ##[1:8]
		($changed(angle_out) || mode_out != twac_pkg::ST_HIGH))
		else $error("high rate stalled");
	AST_CMP_HIT:
	assert property (compare_hit_out == exp_hit)
		else $error("compare hit wrong");
	AST_HALT_WAKE:
	assert property (mode_out == twac_pkg::ST_HALT && $rose(tooth_in)
		|-> ##[2:6] mode_out == twac_pkg::ST_NORMAL)
		else $error("tooth did not leave halt");
	AST_HALT_STILL:
	assert property ($past(mode_out) == twac_pkg::ST_HALT &&
		mode_out == twac_pkg::ST_HALT |-> $stable(angle_out))
		else $error("angle moved in halt");
	AST_ONE_MODE:
	assert property ($onehot(mode_out))
		else $error("mode not one hot");
	AST_RD_IDLE:
	assert property (!$past(rd_en_in) |-> rd_data_out == 32'h0)
		else $error("read data outside read cycle");
endmodule : twac_checker

// ### test/twac_tooth_model.sv
// filtered tooth sensor model
module twac_tooth_model (
	input wire logic sys_clk_in,
	input wire logic fire_in,
	input wire logic [3:0] len_in,
	output logic tooth_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] left = 4'h0;
	// clean level held len cycles, low between teeth
	always @(posedge sys_clk_in) begin
		if (fire_in)
			left <= len_in;
		else if (left != 4'h0)
			left <= left - 4'h1;
	end
	assign tooth_out = (left != 4'h0);
endmodule : twac_tooth_model
